// ==== lrc_checker.sv ====
// concurrent checks on the regulator control top ports
`timescale 1ns/1ns
`default_nettype none
module lrc_checker
    import lrc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] power_state,
    input wire logic [1:0] reg_a_load_switch_fuse,
    input wire logic processor_reset_out_n,
    input wire logic system_rail_above_upper,
    input wire logic system_rail_below_lower,
    input wire logic system_rail_present,
    input wire logic coin_cell_present,
    input wire logic [NREG-1:0] reg_on,
    input wire logic [NREG-1:0] reg_low_power,
    input wire logic [NREG-1:0] reg_pulldown,
    input wire logic [NREG-1:0] reg_soft_start,
    input wire logic [NREG-1:0] reg_current_limit_en,
    input wire logic [11:0] reg_b_mv,
    input wire logic backup_from_system_rail,
    input wire logic backup_switch_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // two-cycle antecedents tolerate either registering order of the outputs
    a_pulldown_off: assert property (!reg_on[1] [*2] |-> reg_pulldown[1])
        else $error("no pulldown on disabled regulator");
    a_pulldown_cpu_rst: assert property (!processor_reset_out_n [*2] |-> reg_pulldown[2])
        else $error("no pulldown while processor reset low");
    a_run_no_lp: assert property (power_state == LRC_RUN [*2] |-> reg_low_power == 3'h0)
        else $error("low power in run state");
    a_lp_needs_on: assert property (reg_low_power[2] |-> reg_on[2])
        else $error("low power on disabled regulator");
    a_switch_no_limit: assert property (reg_a_load_switch_fuse[0] [*2] |-> !reg_current_limit_en[0])
        else $error("current limit active in load switch");
    a_limit_kept: assert property (!reg_a_load_switch_fuse[1] [*2] |-> reg_current_limit_en[1])
        else $error("current limit off on regulator");
    a_rail_select: assert property (system_rail_above_upper [*3] |-> backup_from_system_rail)
        else $error("rail above upper not selected");
    a_cell_select: assert property ((system_rail_below_lower && coin_cell_present) [*3]
        |-> !backup_from_system_rail)
        else $error("coin cell not selected");
    a_source_hold: assert property ((!system_rail_above_upper && !system_rail_below_lower
        && system_rail_present) [*3] |-> $stable(backup_from_system_rail))
        else $error("source changed between thresholds");
    a_cell_switch: assert property ((!system_rail_present && coin_cell_present) [*3]
        |-> backup_switch_mode && !backup_from_system_rail)
        else $error("no switch mode after rail removal");
    a_soft_start: assert property ($rose(reg_on[1]) |-> ##[0:1] reg_soft_start[1])
        else $error("enable without soft start");
    a_b_grid: assert property (reg_b_mv != 12'h0 |-> reg_b_mv >= MV_B_BASE
        && reg_b_mv <= 12'hce4 && reg_b_mv % 12'h64 == 12'h0)
        else $error("type b voltage off grid");
endmodule : lrc_checker
`default_nettype wire

// ==== lrc_cpu_model.sv ====
// system processor model: AXI4-Lite master for register access
`timescale 1ns/1ns
`default_nettype none
module lrc_cpu_model
    import lrc_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // ready lines stay high: one access at a time, so no answer arrives unasked
    initial begin
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
endmodule : lrc_cpu_model
`default_nettype wire

// ==== lrc_pkg.sv ====
// package: register map, field layouts, enumerations and timing for regulator control
package lrc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL_A0 = 8'h00;
    localparam logic [7:0] OFF_CTRL_A1 = 8'h04;
    localparam logic [7:0] OFF_CTRL_B = 8'h08;
    localparam logic [7:0] OFF_GLOBAL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // control word layout (regulator control registers)
    localparam int unsigned F_EN = 0;
    localparam int unsigned F_STBY = 1;
    localparam int unsigned F_SLP = 2;
    localparam int unsigned F_LP = 3;
    localparam int unsigned F_CODE = 8;
    localparam int unsigned CODE_A_W = 5;
    localparam int unsigned CODE_B_W = 4;
    localparam int unsigned F_SCP = 0;
    // fault / status bit positions: a0, a1, b
    localparam int unsigned NREG = 3;
    localparam int unsigned IDX_B = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [2:0] MASK_RST = 3'h7;
    // status register layout
    localparam int unsigned S_ON = 0;
    localparam int unsigned S_LP = 4;
    localparam int unsigned S_DIS = 8;
    localparam int unsigned S_SS = 12;
    localparam int unsigned S_BK = 16;
    // voltage in mV
    localparam logic [11:0] MV_A_LO_BASE = 12'd750;
    localparam logic [11:0] MV_A_LO_STEP = 12'd50;
    localparam logic [11:0] MV_A_HI_BASE = 12'd1800;
    localparam logic [11:0] MV_HI_STEP = 12'd100;
    localparam logic [11:0] MV_B_BASE = 12'd1800;
    // soft-start ramp
    localparam int unsigned SS_TIME_US = 10;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned SS_CYC = SS_TIME_US * CLK_MHZ;
    localparam int unsigned SS_W = 10;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        LRC_RUN = 2'b00,
        LRC_STANDBY = 2'b01,
        LRC_SLEEP = 2'b11
    } lrc_pstate_t;
    typedef enum logic [1:0] {
        LRC_OFF = 2'b00,
        LRC_RAMP = 2'b01,
        LRC_ON = 2'b11
    } lrc_ss_t;
endpackage : lrc_pkg

// ==== lrc_softstart.sv ====
// one regulator channel: soft-start ramp sequencer; the load_switch input is not used
`timescale 1ns/1ns
`default_nettype none
module lrc_softstart
    import lrc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable_req,
    input wire logic load_switch,
    output logic ramping,
    output logic settled
);
    lrc_ss_t state_reg;
    logic [SS_W-1:0] cnt_reg;
    localparam logic [SS_W-1:0] SS_LAST = SS_W'(SS_CYC - 1);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= LRC_OFF;
            cnt_reg <= '0;
        end else if (!enable_req) begin
            state_reg <= LRC_OFF;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                LRC_OFF: begin
                    state_reg <= LRC_RAMP;
                    cnt_reg <= '0;
                end
                LRC_RAMP: begin
                    if (cnt_reg == SS_LAST) begin
                        state_reg <= LRC_ON;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
                LRC_ON: state_reg <= LRC_ON;
                default: state_reg <= LRC_OFF;
            endcase
        end
    end

    assign ramping = (state_reg == LRC_RAMP);
    assign settled = (state_reg == LRC_ON);
endmodule : lrc_softstart
`default_nettype wire

// ==== lrc_top.sv ====
// regulator control top: AXI4-Lite registers, mode decode, fault handling, backup supply select
//
// Notes on behaviour
// - type A code: 0-15 give 0.75-1.5 V by 50 mV, 16-31 1.8-3.3 V.
// - type B code 0 is 1.80 V, plus 100 mV per step to 3.30 V.
// - type A off if enable clear; standby and sleep need their extra enables.
// - low-power bit applies only in standby and sleep for enabled regulators.
// - type B uses the same enable and low-power decode.
// - type A overcurrent with shutdown enabled clears enable and sets fault flag; a type A load switch ignores its overcurrent.
// - type B overcurrent with shutdown enabled clears enable and sets fault flag.
// - each fault flag has its own interrupt mask bit.
// - shutdown enable resets clear; then overloaded regulator stays on, current-limited.
// - fault flag sets on overload regardless of shutdown enable; never set for a type A load switch.
// - load-switch fuse: pass device fully on, no current limit, soft-start.
// - pulldown whenever disabled; type B also while processor reset low.
// - each enable ramps the reference through soft-start.
// - system rail above upper threshold selects it; below lower selects coin cell if coin cell present.
// - rail removed with coin cell present: switch mode from coin cell.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module lrc_top
    import lrc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] power_state,
    input wire logic [NREG-1:0] overcurrent,
    input wire logic [1:0] reg_a_load_switch_fuse,
    input wire logic processor_reset_out_n,
    input wire logic system_rail_above_upper,
    input wire logic system_rail_below_lower,
    input wire logic system_rail_present,
    input wire logic coin_cell_present,
    output logic [NREG-1:0] reg_on,
    output logic [NREG-1:0] reg_low_power,
    output logic [NREG-1:0] reg_pulldown,
    output logic [NREG-1:0] reg_soft_start,
    output logic [NREG-1:0] reg_current_limit_en,
    output logic [1:0] reg_a_pass_full_on,
    output logic [11:0] reg_a0_mv,
    output logic [11:0] reg_a1_mv,
    output logic [11:0] reg_b_mv,
    output logic backup_from_system_rail,
    output logic backup_switch_mode,
    output logic irq
);
    logic [31:0] ctrl_reg [NREG];
    logic short_circuit_shutdown_enable_reg;
    logic [NREG-1:0] fault_flag_reg;
    logic [NREG-1:0] fault_mask_reg;
    logic backup_sys_reg;
    logic [NREG-1:0] en_bit, stby_bit, slp_bit, lp_bit, want_on, want_lp;
    logic [NREG-1:0] ramping, settled, ss_req;
    logic [11:0] mv_a0, mv_a1, mv_b, mv_unused;
    logic [NREG-1:0] is_lswitch;
    assign is_lswitch = {1'b0, reg_a_load_switch_fuse};

    // write channel
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_hit;

    assign waddr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wdata = w_held_reg ? wdata_reg : s_axi_wdata;
    assign wstrb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
        && (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
    end

    // ready only while nothing is parked, so one write at a time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !do_write;
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !do_write;
        end
    end

    always_comb begin
        unique case (waddr)
            OFF_CTRL_A0, OFF_CTRL_A1, OFF_CTRL_B, OFF_GLOBAL, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // per-regulator control words and fault shutdown
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            localparam logic [7:0] OFF = (gi == 0) ? OFF_CTRL_A0 : (gi == 1) ? OFF_CTRL_A1 : OFF_CTRL_B;
            logic [31:0] merged;
            always_comb begin
                for (int b = 0; b < 4; b++) begin
                    merged[8*b +: 8] = wstrb[b] ? wdata[8*b +: 8] : ctrl_reg[gi][8*b +: 8];
                end
            end
            // shutdown on overcurrent beats software write
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    ctrl_reg[gi] <= CTRL_RST;
                end else begin
                    if (do_write && waddr == OFF) begin
                        ctrl_reg[gi] <= merged;
                    end
                    if (short_circuit_shutdown_enable_reg && overcurrent[gi] && !is_lswitch[gi]) begin
                        ctrl_reg[gi][F_EN] <= 1'b0;
                    end
                end
            end
            assign en_bit[gi] = ctrl_reg[gi][F_EN];
            assign stby_bit[gi] = ctrl_reg[gi][F_STBY];
            assign slp_bit[gi] = ctrl_reg[gi][F_SLP];
            assign lp_bit[gi] = ctrl_reg[gi][F_LP];

            always_comb begin
                unique case (power_state)
                    LRC_RUN: want_on[gi] = en_bit[gi];
                    LRC_STANDBY: want_on[gi] = en_bit[gi] && stby_bit[gi];
                    LRC_SLEEP: want_on[gi] = en_bit[gi] && slp_bit[gi];
                    default: want_on[gi] = 1'b0;
                endcase
            end
            assign want_lp[gi] = want_on[gi] && lp_bit[gi] && (power_state != LRC_RUN);
            assign ss_req[gi] = want_on[gi];

            lrc_softstart u_ss (
                .ref_clk(ref_clk),
                .rst(rst),
                .enable_req(ss_req[gi]),
                .load_switch(is_lswitch[gi]),
                .ramping(ramping[gi]),
                .settled(settled[gi])
            );

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    reg_on[gi] <= 1'b0;
                    reg_low_power[gi] <= 1'b0;
                    reg_soft_start[gi] <= 1'b0;
                    reg_pulldown[gi] <= 1'b1;
                    reg_current_limit_en[gi] <= 1'b1;
                end else begin
                    reg_on[gi] <= want_on[gi];
                    reg_low_power[gi] <= want_lp[gi];
                    reg_soft_start[gi] <= ramping[gi];
                    // discharge when disabled; type B also in processor reset
                    reg_pulldown[gi] <= !want_on[gi] || (gi == IDX_B && !processor_reset_out_n);
                    // no current limit as load switch
                    reg_current_limit_en[gi] <= !is_lswitch[gi];
                end
            end
        end
    endgenerate

    // pass device fully on once switch ramp done
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_a_pass_full_on <= '0;
        end else begin
            reg_a_pass_full_on <= reg_a_load_switch_fuse & want_on[1:0] & settled[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            short_circuit_shutdown_enable_reg <= 1'b0;
        end else if (do_write && waddr == OFF_GLOBAL && wstrb[0]) begin
            short_circuit_shutdown_enable_reg <= wdata[F_SCP];
        end
    end

    // flag on overload either way, load switches excepted; set wins over clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_flag_reg <= '0;
        end else begin
            if (do_write && waddr == OFF_IRQ_STAT && wstrb[0]) begin
                fault_flag_reg <= (fault_flag_reg & ~wdata[NREG-1:0]) | (overcurrent & ~is_lswitch);
            end else begin
                fault_flag_reg <= fault_flag_reg | (overcurrent & ~is_lswitch);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_mask_reg <= MASK_RST;
        end else if (do_write && waddr == OFF_IRQ_MASK && wstrb[0]) begin
            fault_mask_reg <= wdata[NREG-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(fault_flag_reg & ~fault_mask_reg);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            backup_sys_reg <= 1'b1;
        end else if (!system_rail_present && coin_cell_present) begin
            backup_sys_reg <= 1'b0;
        end else if (system_rail_above_upper) begin
            backup_sys_reg <= 1'b1;
        end else if (system_rail_below_lower && coin_cell_present) begin
            backup_sys_reg <= 1'b0;
        end
    end

    // coin cell feeds through a switch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            backup_from_system_rail <= 1'b1;
            backup_switch_mode <= 1'b0;
        end else begin
            backup_from_system_rail <= backup_sys_reg;
            backup_switch_mode <= !backup_sys_reg;
        end
    end

    lrc_voltage_decode u_dec0 (
        .code_a(ctrl_reg[0][F_CODE +: CODE_A_W]),
        .code_b(ctrl_reg[IDX_B][F_CODE +: CODE_B_W]),
        .mv_a(mv_a0),
        .mv_b(mv_b)
    );
    lrc_voltage_decode u_dec1 (
        .code_a(ctrl_reg[1][F_CODE +: CODE_A_W]),
        .code_b(ctrl_reg[IDX_B][F_CODE +: CODE_B_W]),
        .mv_a(mv_a1),
        .mv_b(mv_unused)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_a0_mv <= '0;
            reg_a1_mv <= '0;
            reg_b_mv <= '0;
        end else begin
            reg_a0_mv <= mv_a0;
            reg_a1_mv <= mv_a1;
            reg_b_mv <= mv_b;
        end
    end

    // read channel, answers one cycle after address taken
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = '0;
        unique case (s_axi_araddr)
            OFF_CTRL_A0: rd_mux = ctrl_reg[0];
            OFF_CTRL_A1: rd_mux = ctrl_reg[1];
            OFF_CTRL_B: rd_mux = ctrl_reg[IDX_B];
            OFF_GLOBAL: rd_mux[F_SCP] = short_circuit_shutdown_enable_reg;
            OFF_IRQ_STAT: rd_mux[NREG-1:0] = fault_flag_reg;
            OFF_IRQ_MASK: rd_mux[NREG-1:0] = fault_mask_reg;
            OFF_STATUS: begin
                rd_mux[S_ON +: NREG] = reg_on;
                rd_mux[S_LP +: NREG] = reg_low_power;
                rd_mux[S_DIS +: NREG] = reg_pulldown;
                rd_mux[S_SS +: NREG] = reg_soft_start;
                rd_mux[S_BK] = backup_sys_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : lrc_top
`default_nettype wire

// ==== lrc_voltage_decode.sv ====
// voltage code decode to millivolts for both regulator types
`timescale 1ns/1ns
`default_nettype none
module lrc_voltage_decode
    import lrc_pkg::*;
(
    input wire logic [CODE_A_W-1:0] code_a,
    input wire logic [CODE_B_W-1:0] code_b,
    output logic [11:0] mv_a,
    output logic [11:0] mv_b
);
    logic [11:0] low_a;
    assign low_a = {8'h00, code_a[CODE_A_W-2:0]};
    // two ranges split by code msb
    always_comb begin
        if (code_a[CODE_A_W-1]) begin
            mv_a = MV_A_HI_BASE + 12'(low_a * MV_HI_STEP);
        end else begin
            mv_a = MV_A_LO_BASE + 12'(low_a * MV_A_LO_STEP);
        end
    end
    // 1.8 V plus 100 mV steps
    assign mv_b = MV_B_BASE + 12'({8'h00, code_b} * MV_HI_STEP);
endmodule : lrc_voltage_decode
`default_nettype wire

// ==== testbench.sv ====
// self-checking testbench for the regulator control top
`timescale 1ns/1ns
`default_nettype none
module testbench
    import lrc_pkg::*;
;
    logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, processor_reset_out_n, irq, cut;
    logic system_rail_above_upper, system_rail_below_lower, system_rail_present, coin_cell_present;
    logic backup_from_system_rail, backup_switch_mode;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb, ctl;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_state, resp, pst, reg_a_pass_full_on, reg_a_load_switch_fuse;
    logic [NREG-1:0] overcurrent, reg_on, reg_low_power, reg_pulldown, reg_soft_start, reg_current_limit_en;
    logic [11:0] reg_a0_mv, reg_a1_mv, reg_b_mv;
    // inputs {above, below, present, coin} and the source expected
    logic [3:0] bk_in [6] = '{4'hb, 4'h3, 4'h7, 4'h3, 4'hb, 4'h5};
    logic bk_exp [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    int num_errors = 0;
    int comparisons = 0;
    lrc_top dut (.*);
    lrc_cpu_model cpu (.*);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s at %0t: got %h expected %h", what, $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic regw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        cpu.wr(a, d, resp);
        check("bresp", {30'h0, resp}, {30'h0, AXI_OKAY});
    endtask : regw
    task automatic regr(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        cpu.rd(a, rd_val, resp);
        check("rdata", rd_val, exp);
    endtask : regr
    function automatic logic [11:0] exp_mv(input logic [4:0] c);
        return c[4] ? 12'h708 + 12'h64 * {8'h0, c[3:0]} : 12'h2ee + 12'h32 * {8'h0, c[3:0]};
    endfunction : exp_mv
    function automatic logic exp_on(input logic [3:0] c, input logic [1:0] s);
        return c[0] && (s == LRC_RUN || (s == LRC_STANDBY && c[1]) || (s == LRC_SLEEP && c[2]));
    endfunction : exp_on
    initial begin
        rst = 1'b1;
        power_state = LRC_RUN;
        overcurrent = 3'h0;
        reg_a_load_switch_fuse = 2'b01;
        processor_reset_out_n = 1'b1;
        {system_rail_above_upper, system_rail_below_lower, system_rail_present, coin_cell_present} = 4'hb;
        void'($urandom(32'h5e4a));
        tick(16);
        rst <= 1'b0;
        tick(1);
        regr(OFF_GLOBAL, 32'h0);
        regr(OFF_IRQ_MASK, 32'h7);
        cpu.rd(8'h1c, rd_val, resp);
        check("unmapped", {30'h0, resp}, {30'h0, AXI_SLVERR});
        check("pd_reset", reg_pulldown, 3'h7);
        $display("test reset done");
        for (int c = 0; c < 32; c++) begin
            regw(OFF_CTRL_A1, {19'h0, c[4:0], 8'h01});
            regw(OFF_CTRL_B, {20'h0, c[3:0], 8'h01});
            tick(3);
            check("a1_mv", reg_a1_mv, exp_mv(c[4:0]));
            check("b_mv", reg_b_mv, exp_mv({1'b1, c[3:0]}));
        end
        $display("test decode done");
        repeat (40) begin
            ctl = 4'($urandom_range(15, 0));
            pst = 2'($urandom_range(3, 0));
            cut = 1'($urandom_range(1, 0));
            regw(OFF_CTRL_A1, {28'h0, ctl});
            regw(OFF_CTRL_B, {28'h0, ctl});
            power_state <= pst;
            processor_reset_out_n <= cut;
            tick(3);
            check("a1_on", reg_on[1], exp_on(ctl, pst));
            check("b_on", reg_on[2], exp_on(ctl, pst));
            check("b_lp", reg_low_power[2], exp_on(ctl, pst) && ctl[3] && pst != LRC_RUN);
            check("b_pd", reg_pulldown[2], !exp_on(ctl, pst) || !cut);
        end
        power_state <= LRC_RUN;
        processor_reset_out_n <= 1'b1;
        $display("test modes done");
        regw(OFF_CTRL_B, 32'h0);
        tick(3);
        regw(OFF_CTRL_A0, 32'h1);
        regw(OFF_CTRL_B, 32'h1);
        tick(3);
        check("ramp", reg_soft_start[2], 1'b1);
        tick(SS_CYC);
        check("ramp_end", reg_soft_start[2], 1'b0);
        check("full_on", reg_a_pass_full_on, 2'h1);
        regw(OFF_CTRL_A1, 32'h1);
        regw(OFF_IRQ_MASK, 32'h0);
        overcurrent <= 3'b010;
        tick(4);
        check("limit_on", reg_on[1], 1'b1);
        check("irq", irq, 1'b1);
        overcurrent <= 3'b000;
        regw(OFF_IRQ_MASK, 32'h2);
        tick(3);
        check("masked", irq, 1'b0);
        regw(OFF_IRQ_STAT, 32'h2);
        regr(OFF_IRQ_STAT, 32'h0);
        regw(OFF_GLOBAL, 32'h1);
        // the load switch has no current limit, so its overcurrent is ignored
        overcurrent <= 3'b111;
        tick(4);
        check("shut", reg_on[2:1], 2'b00);
        check("irq_b", irq, 1'b1);
        overcurrent <= 3'b000;
        regr(OFF_CTRL_A1, 32'h0);
        regr(OFF_CTRL_B, 32'h0);
        regr(OFF_IRQ_STAT, 32'h6);
        regw(OFF_IRQ_STAT, 32'h7);
        tick(3);
        check("irq_clr", irq, 1'b0);
        $display("test faults done");
        foreach (bk_in[i]) begin
            {system_rail_above_upper, system_rail_below_lower, system_rail_present, coin_cell_present} <= bk_in[i];
            tick(3);
            check("backup", backup_from_system_rail, bk_exp[i]);
        end
        check("switch", backup_switch_mode, 1'b1);
        $display("test backup done");
        close_out();
    end
    initial begin
        tick(20000);
        num_errors++;
        close_out();
    end
endmodule : testbench
bind lrc_top lrc_checker chk (.*);
`default_nettype wire
